//--- verilog/urs_regs.svh
// Offsets, field positions and reset values of the per-port state store
`ifndef URS_REGS_SVH
`define URS_REGS_SVH
`define URS_BASE_ADDR 20'hBE000
`define URS_BASE_HI 10'h2F8
`define URS_PORTS 28
`define URS_LAST_PORT 5'h1B
`define URS_WORDS 12
`define URS_STRUCT_BYTES 32
`define URS_OFS_PORT_CLK 5'h00
`define URS_OFS_MAX_LEAD 5'h02
`define URS_OFS_TS_SEQ 5'h04
`define URS_OFS_INIT_CD 5'h06
`define URS_OFS_WR_PTR 5'h08
`define URS_OFS_RD_AVG 5'h0A
`define URS_OFS_CELLS 5'h0C
`define URS_OFS_SEQ_HDR 5'h0E
`define URS_OFS_MIS_LOST 5'h10
`define URS_OFS_OVF_UND 5'h12
`define URS_OFS_LATE 5'h14
`define URS_OFS_ARR_RO 5'h16
`define URS_W_PORT_CLK 4'h0
`define URS_W_MAX_LEAD 4'h1
`define URS_W_TS_SEQ 4'h2
`define URS_W_INIT_CD 4'h3
`define URS_W_WR_PTR 4'h4
`define URS_W_RD_AVG 4'h5
`define URS_W_CELLS 4'h6
`define URS_W_SEQ_HDR 4'h7
`define URS_W_MIS_LOST 4'h8
`define URS_W_OVF_UND 4'h9
`define URS_W_LATE 4'hA
`define URS_W_ARR_RO 4'hB
`define URS_BIT_SRTS 5
`define URS_BIT_ADAPT 6
`define URS_BIT_INIT 4
`define URS_BIT_CD 3
`define URS_BIT_ARRIVAL 15
`define URS_PTR_W 12
`define URS_RESET_WORD 16'h0000
`define URS_CNT_NUM 8
`endif

//--- verilog/urs_pkg.sv
// Types shared by the per-port reassembly state store
package urs_pkg;
    typedef logic [15:0] urs_word_type;
    typedef logic [4:0] urs_port_type;
    typedef logic [11:0] urs_ptr_type;
    // Statistics counters in rollover-bit order
    typedef enum logic [2:0] {
        URS_CNT_CELLS = 3'h0,
        URS_CNT_HDR = 3'h1,
        URS_CNT_SEQ = 3'h2,
        URS_CNT_LOST = 3'h3,
        URS_CNT_MIS = 3'h4,
        URS_CNT_UND = 3'h5,
        URS_CNT_OVF = 3'h6,
        URS_CNT_LATE = 3'h7
    } urs_cnt_type;
endpackage

//--- verilog/urs_stat_counter.sv
// Wrapping statistics counter step with rollover detect
`timescale 1ns/100ps
module urs_stat_counter #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] count_in,
    input wire logic inc_in,
    output logic [WIDTH-1:0] count_out,
    output logic wrap_out
);
    // Natural wrap to zero on overflow
    always_comb begin
        count_out = count_in + WIDTH'(inc_in);
        wrap_out = inc_in & (&count_in);
    end
endmodule

//--- verilog/urs_state_store.sv
// Per-port unstructured reassembly control structure store
`timescale 1ns/100ps
`include "urs_regs.svh"

// Contract
// R1: One internal memory holds up to 28 structures, one per port.
// R2: Each port's structure occupies its own 32-byte block.
// R3: Port p structure begins at byte BE000h plus p times 32.
// R4: Software programs destination port 0 to 27 matching its location.
// R5: Set srts enable marks circuit as carrying residual time stamps.
// R6: Max lead bounds distance between read and write pointers.
// R7: Software zeroes all other fields when initialising.
// R8: Init flag reads 0 uninitialised, 1 after; software clears it.
// R9: Next correction state bit kept; software initialises it to 0.
// R10: Keep last sequence, last good sequence and fast machine state.
// R11: Keep three-bit time stamp bits 3:1 plus three validity flags.
// R12: Keep three-bit previous valid sequence number of in-sync cells.
// R13: Write pointer holds next location and advances as data stored.
// R14: Read-only read pointer plus average, zero unless underrun reported.
// R15: Count seven error kinds in 8 bits, cells in 16 bits.
// R16: Arrival flag set on every cell; software may clear it.
// R17: CPU can read every structure word.
// R18: Software sets up a structure for every receiving circuit.
// R19: Adaptive enable uses buffer fill level for clock recovery.
// R20: Eight rollover bits in field order, bit 0 cells, bit 1 header.
// R21: Counter passing maximum wraps to zero, sets sticky rollover bit.
module urs_state_store (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // CPU port, 16-bit words
    input wire logic [19:0] cpu_addr_in,
    input wire logic cpu_cs_in,
    input wire logic cpu_rd_in,
    input wire logic cpu_wr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic cpu_ready_out,
    output logic cpu_ack_out,
    output logic [15:0] cpu_rdata_out,
    // Per-cell update from the reassembly engine
    input wire logic upd_valid_in,
    input wire logic [4:0] upd_port_in,
    input wire logic [7:0] upd_count_in,
    input wire logic [2:0] upd_last_seq_in,
    input wire logic [2:0] upd_last_good_in,
    input wire logic [3:0] upd_fast_state_in,
    input wire logic upd_cd_state_in,
    input wire logic [2:0] upd_rts_in,
    input wire logic [2:0] upd_rts_valid_in,
    input wire logic [2:0] upd_prev_valid_seq_in,
    input wire logic upd_wr_adv_in,
    input wire logic [11:0] upd_rd_avg_in,
    // Configuration lookup for the engine and clock recovery
    input wire logic [4:0] look_port_in,
    input wire logic [11:0] look_tdm_rd_ptr_in,
    output logic [4:0] look_dest_port_out,
    output logic look_srts_en_out,
    output logic look_adapt_en_out,
    output logic [11:0] look_max_lead_out,
    output logic [11:0] look_wr_ptr_out,
    output logic [11:0] look_fill_out,
    output logic look_lead_over_out,
    output logic [2:0] look_rts_out,
    output logic [2:0] look_rts_valid_out,
    output logic look_init_out,
    output logic look_cd_state_out,
    output logic [3:0] look_fast_state_out
);
    // ==========================================================
    // Storage
    // ==========================================================
    urs_pkg::urs_word_type mem_q [`URS_PORTS][`URS_WORDS]; // [R1] [R2]

    logic cpu_hit;
    logic [4:0] cpu_port;
    logic [3:0] cpu_word;
    logic cpu_wr_go;
    logic cpu_rd_go;
    logic [15:0] rdata_q;
    logic ack_q;

    // ==========================================================
    // CPU address decode
    // ==========================================================
    // Block sits on a 1 KB aligned window; port in bits 9:5
    // Address bit 0 is ignored: every field is word wide
    always_comb begin
        cpu_port = cpu_addr_in[9:5]; // [R3]
        cpu_word = cpu_addr_in[4:1];
        cpu_hit = (cpu_addr_in[19:10] == `URS_BASE_HI) &&
                  (cpu_port <= `URS_LAST_PORT) &&
                  (cpu_word < 4'(`URS_WORDS));
    end

    // CPU waits while the engine writes, so the engine's
    // set always lands before any software clear
    assign cpu_ready_out = ~upd_valid_in; // [R16]
    assign cpu_wr_go = cpu_cs_in & cpu_wr_in & cpu_ready_out & clk_en_in;
    assign cpu_rd_go = cpu_cs_in & cpu_rd_in & cpu_ready_out & clk_en_in;

    // ==========================================================
    // Engine update: current structure and new words
    // ==========================================================
    urs_pkg::urs_word_type cur [`URS_WORDS];
    logic [15:0] cnt_cur [`URS_CNT_NUM];
    logic [15:0] cnt_new [`URS_CNT_NUM];
    logic [7:0] cnt_wrap;
    logic srts_en;
    logic [11:0] new_ptr;
    logic [11:0] new_avg;

    always_comb begin
        for (int i = 0; i < `URS_WORDS; i++) begin
            cur[i] = mem_q[upd_port_in][i];
        end
    end

    always_comb begin
        // Narrow counters read with a zero high byte
        cnt_cur[urs_pkg::URS_CNT_CELLS] = cur[`URS_W_CELLS];
        cnt_cur[urs_pkg::URS_CNT_HDR] = {8'h00, cur[`URS_W_SEQ_HDR][7:0]};
        cnt_cur[urs_pkg::URS_CNT_SEQ] = {8'h00, cur[`URS_W_SEQ_HDR][15:8]};
        cnt_cur[urs_pkg::URS_CNT_LOST] = {8'h00, cur[`URS_W_MIS_LOST][7:0]};
        cnt_cur[urs_pkg::URS_CNT_MIS] = {8'h00, cur[`URS_W_MIS_LOST][15:8]};
        cnt_cur[urs_pkg::URS_CNT_UND] = {8'h00, cur[`URS_W_OVF_UND][7:0]};
        cnt_cur[urs_pkg::URS_CNT_OVF] = {8'h00, cur[`URS_W_OVF_UND][15:8]};
        cnt_cur[urs_pkg::URS_CNT_LATE] = {8'h00, cur[`URS_W_LATE][7:0]};
    end

    // Only the cell counter is 16 bits wide
    genvar g;
    generate
        for (g = 0; g < `URS_CNT_NUM; g++) begin : gen_cnt
            if (g == 0) begin : gen_wide
                urs_stat_counter #(.WIDTH(16)) u_cnt (
                    .count_in(cnt_cur[g]),
                    .inc_in(upd_count_in[g]),
                    .count_out(cnt_new[g]),
                    .wrap_out(cnt_wrap[g])
                ); // [R15] [R21]
            end else begin : gen_narrow
                logic [7:0] nxt;
                urs_stat_counter #(.WIDTH(8)) u_cnt (
                    .count_in(cnt_cur[g][7:0]),
                    .inc_in(upd_count_in[g]),
                    .count_out(nxt),
                    .wrap_out(cnt_wrap[g])
                ); // [R15] [R21]
                assign cnt_new[g] = {8'h00, nxt};
            end
        end
    endgenerate

    assign srts_en = cur[`URS_W_PORT_CLK][`URS_BIT_SRTS];

    // Pointer wraps at the field width, the buffer's natural size
    assign new_ptr = cur[`URS_W_WR_PTR][11:0] + 12'(upd_wr_adv_in); // [R13]

    // Underrun latches the pointer sum; any later clean cell clears it
    always_comb begin
        new_avg = cur[`URS_W_RD_AVG][11:0];
        if (upd_count_in[urs_pkg::URS_CNT_UND]) begin
            new_avg = upd_rd_avg_in; // [R14]
        end else if (upd_count_in[urs_pkg::URS_CNT_CELLS]) begin
            new_avg = 12'h000; // [R14]
        end
    end

    // ==========================================================
    // Memory write: engine first, CPU only when engine idle
    // ==========================================================
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int p = 0; p < `URS_PORTS; p++) begin
                for (int w = 0; w < `URS_WORDS; w++) begin
                    mem_q[p][w] <= `URS_RESET_WORD;
                end
            end
        end else if (clk_en_in) begin
            if (upd_valid_in && upd_port_in <= `URS_LAST_PORT) begin
                // Time stamp bits follow only on circuits carrying them
                mem_q[upd_port_in][`URS_W_TS_SEQ] <= {
                    srts_en ? upd_rts_valid_in : cur[`URS_W_TS_SEQ][15:13],
                    srts_en ? upd_rts_in : cur[`URS_W_TS_SEQ][12:10],
                    upd_last_seq_in,
                    upd_last_good_in,
                    upd_fast_state_in}; // [R5] [R10] [R11]

                // Any cell marks the circuit initialised
                mem_q[upd_port_in][`URS_W_INIT_CD] <= {
                    11'h000,
                    1'b1,
                    upd_cd_state_in,
                    srts_en ? upd_prev_valid_seq_in : cur[`URS_W_INIT_CD][2:0]
                }; // [R8] [R9] [R12]

                mem_q[upd_port_in][`URS_W_WR_PTR] <= {4'h0, new_ptr}; // [R13]

                mem_q[upd_port_in][`URS_W_RD_AVG] <= {4'h0, new_avg}; // [R14]

                mem_q[upd_port_in][`URS_W_CELLS] <=
                    cnt_new[urs_pkg::URS_CNT_CELLS]; // [R15]

                mem_q[upd_port_in][`URS_W_SEQ_HDR] <= {
                    cnt_new[urs_pkg::URS_CNT_SEQ][7:0],
                    cnt_new[urs_pkg::URS_CNT_HDR][7:0]}; // [R15]

                mem_q[upd_port_in][`URS_W_MIS_LOST] <= {
                    cnt_new[urs_pkg::URS_CNT_MIS][7:0],
                    cnt_new[urs_pkg::URS_CNT_LOST][7:0]}; // [R15]

                mem_q[upd_port_in][`URS_W_OVF_UND] <= {
                    cnt_new[urs_pkg::URS_CNT_OVF][7:0],
                    cnt_new[urs_pkg::URS_CNT_UND][7:0]}; // [R15]

                mem_q[upd_port_in][`URS_W_LATE] <= {
                    8'h00, cnt_new[urs_pkg::URS_CNT_LATE][7:0]}; // [R15]

                // Arrival and rollovers are sticky until software clears
                mem_q[upd_port_in][`URS_W_ARR_RO] <= {
                    1'b1,
                    7'h00,
                    cur[`URS_W_ARR_RO][7:0] | cnt_wrap}; // [R16] [R20] [R21]
            end else if (cpu_wr_go && cpu_hit) begin
                // Whole word replaced, counters and flags included
                // Read pointer sum is read-only to software
                if (cpu_word != `URS_W_RD_AVG) begin
                    mem_q[cpu_port][cpu_word] <= cpu_wdata_in; // [R3] [R8]
                end
            end
        end
    end

    // ==========================================================
    // CPU read: one-cycle registered answer, zero when unmapped
    // ==========================================================
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_q <= 16'h0000;
        end else if (clk_en_in) begin
            if (cpu_rd_go) begin
                rdata_q <= cpu_hit ? mem_q[cpu_port][cpu_word] : 16'h0000; // [R17]
            end
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
        end else if (clk_en_in) begin
            // Unmapped requests are acknowledged too, so the CPU never hangs
            ack_q <= cpu_rd_go | cpu_wr_go;
        end
    end

    assign cpu_ack_out = ack_q;
    assign cpu_rdata_out = rdata_q;

    // ==========================================================
    // Configuration lookup for the engine
    // ==========================================================
    urs_pkg::urs_word_type lk [`URS_WORDS];
    logic look_ok;
    logic [11:0] lk_fill;

    always_comb begin
        look_ok = (look_port_in <= `URS_LAST_PORT);
        for (int i = 0; i < `URS_WORDS; i++) begin
            lk[i] = look_ok ? mem_q[look_port_in][i] : `URS_RESET_WORD;
        end
    end

    // Fill is the write lead over the TDM reader, modulo buffer size
    assign lk_fill = lk[`URS_W_WR_PTR][11:0] - look_tdm_rd_ptr_in;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_dest_port_out <= 5'h00;
            look_srts_en_out <= 1'b0;
            look_adapt_en_out <= 1'b0;
        end else if (clk_en_in) begin
            look_dest_port_out <= lk[`URS_W_PORT_CLK][4:0];
            look_srts_en_out <= lk[`URS_W_PORT_CLK][`URS_BIT_SRTS]; // [R5]
            look_adapt_en_out <= lk[`URS_W_PORT_CLK][`URS_BIT_ADAPT]; // [R19]
        end
    end

    // Buffer pointers, kept apart from the circuit's configuration
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_max_lead_out <= 12'h000;
            look_wr_ptr_out <= 12'h000;
        end else if (clk_en_in) begin
            look_max_lead_out <= lk[`URS_W_MAX_LEAD][11:0]; // [R6]
            look_wr_ptr_out <= lk[`URS_W_WR_PTR][11:0]; // [R13]
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_fill_out <= 12'h000;
        end else if (clk_en_in) begin
            // Fill level only offered when adaptive recovery is on
            look_fill_out <= lk[`URS_W_PORT_CLK][`URS_BIT_ADAPT] ?
                             lk_fill : 12'h000; // [R19]
        end
    end

    // Lead check runs whatever the recovery mode, so slips still show
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_lead_over_out <= 1'b0;
        end else if (clk_en_in) begin
            look_lead_over_out <= lk_fill > lk[`URS_W_MAX_LEAD][11:0]; // [R6]
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_rts_out <= 3'h0;
            look_rts_valid_out <= 3'h0;
        end else if (clk_en_in) begin
            // Validity masked so a non-time-stamp circuit feeds no PLL
            look_rts_out <= lk[`URS_W_TS_SEQ][12:10]; // [R11]
            look_rts_valid_out <= lk[`URS_W_PORT_CLK][`URS_BIT_SRTS] ?
                                  lk[`URS_W_TS_SEQ][15:13] : 3'h0; // [R5] [R11]
        end
    end

    // Sequence machine state handed back to the engine
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            look_init_out <= 1'b0;
            look_cd_state_out <= 1'b0;
            look_fast_state_out <= 4'h0;
        end else if (clk_en_in) begin
            look_init_out <= lk[`URS_W_INIT_CD][`URS_BIT_INIT]; // [R8]
            look_cd_state_out <= lk[`URS_W_INIT_CD][`URS_BIT_CD]; // [R9]
            look_fast_state_out <= lk[`URS_W_TS_SEQ][3:0]; // [R10]
        end
    end
endmodule

//--- testbench/urs_state_store_properties.sv
// Port-level concurrent checks for the per-port state store
`timescale 1ns/100ps
module urs_state_store_properties (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [19:0] cpu_addr_in,
    input wire logic cpu_cs_in,
    input wire logic cpu_rd_in,
    input wire logic cpu_wr_in,
    input wire logic cpu_ready_out,
    input wire logic cpu_ack_out,
    input wire logic [15:0] cpu_rdata_out,
    input wire logic upd_valid_in,
    input wire logic [4:0] look_port_in,
    input wire logic [11:0] look_tdm_rd_ptr_in,
    input wire logic [4:0] look_dest_port_out,
    input wire logic look_srts_en_out,
    input wire logic look_adapt_en_out,
    input wire logic [11:0] look_max_lead_out,
    input wire logic [11:0] look_wr_ptr_out,
    input wire logic [11:0] look_fill_out,
    input wire logic look_lead_over_out,
    input wire logic [2:0] look_rts_out,
    input wire logic [2:0] look_rts_valid_out,
    input wire logic look_init_out
);
    // ==========================================
    // Request decode and named steps
    wire logic rd_take = clk_en_in && cpu_cs_in && cpu_rd_in && !upd_valid_in;
    wire logic any_take = clk_en_in && cpu_cs_in && (cpu_rd_in || cpu_wr_in) && !upd_valid_in;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence cpu_take_s;
        any_take;
    endsequence
    sequence stray_read_s;
        rd_take && cpu_addr_in[19:10] != 10'h2F8;
    endsequence
    sequence far_lookup_s;
        clk_en_in && look_port_in > 5'h1B;
    endsequence
    // ==========================================
    // Assertions
    ack_follows_take_a:
        assert property (cpu_take_s |=> cpu_ack_out) else $error("ack missing after request");
    ack_needs_take_a:
        assert property (cpu_ack_out |-> $past(any_take)) else $error("ack without request");
    stray_read_zero_a:
        assert property (stray_read_s |=> cpu_rdata_out == 16'h0000) else $error("stray read data");
    rdata_holds_a:
        assert property (!rd_take |=> $stable(cpu_rdata_out)) else $error("read data moved");
    update_stalls_cpu_a:
        assert property (cpu_ready_out == !upd_valid_in) else $error("ready not stalled");
    srts_off_hides_a:
        assert property (!look_srts_en_out |-> look_rts_out == 3'h0 && look_rts_valid_out == 3'h0)
            else $error("time stamp shown while off");
    adapt_off_fill_a:
        assert property (!look_adapt_en_out |-> look_fill_out == 12'h000) else $error("fill not zero");
    lead_over_cmp_a:
        assert property ($past(clk_en_in) |-> look_lead_over_out ==
            (12'(look_wr_ptr_out - $past(look_tdm_rd_ptr_in)) > look_max_lead_out))
            else $error("lead over flag wrong");
    far_port_zero_a:
        assert property (far_lookup_s |=> look_dest_port_out == 5'h00 && !look_init_out)
            else $error("out of range lookup not zero");
endmodule
bind urs_state_store urs_state_store_properties i_props (.clock_in, .sys_rst_in, .clk_en_in,
    .cpu_addr_in, .cpu_cs_in, .cpu_rd_in, .cpu_wr_in, .cpu_ready_out, .cpu_ack_out,
    .cpu_rdata_out, .upd_valid_in, .look_port_in, .look_dest_port_out, .look_srts_en_out,
    .look_adapt_en_out, .look_max_lead_out, .look_fill_out, .look_lead_over_out,
    .look_rts_out, .look_rts_valid_out, .look_init_out, .look_tdm_rd_ptr_in, .look_wr_ptr_out);

//--- testbench/tb_top.sv
// Self-checking bench for the per-port state store
`timescale 1ns/100ps
`include "urs_regs.svh"
module tb_top;
    logic clock_in = 1'b0, sys_rst_in = 1'b1, clk_en = 1'b1, cpu_cs = 1'b0, cpu_rd = 1'b0;
    logic cpu_wr = 1'b0, upd_valid = 1'b0, upd_cd = 1'b0, upd_wr_adv = 1'b0;
    logic [19:0] cpu_addr = 20'h00000;
    logic [15:0] cpu_wdata = 16'h0000, cpu_rdata_out;
    logic [4:0] upd_port = 5'h00, look_port = 5'h00, look_dest_port_out;
    logic [7:0] upd_count = 8'h00;
    logic [2:0] upd_seq = 3'h0, upd_good = 3'h0, upd_rts = 3'h0, upd_rts_v = 3'h0, upd_pv = 3'h0;
    logic [3:0] upd_fast = 4'h0, look_fast_state_out;
    logic [11:0] upd_rd_avg = 12'h000, look_rd = 12'h000, look_max_lead_out, look_wr_ptr_out;
    logic [11:0] look_fill_out;
    logic [2:0] look_rts_out, look_rts_valid_out;
    logic cpu_ready_out, cpu_ack_out, look_srts_en_out, look_adapt_en_out, look_lead_over_out;
    logic look_init_out, look_cd_state_out;
    int n_errors = 0, check_count = 0;
    // ==========================================
    // Clock and device
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end
    urs_state_store i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en),
        .cpu_addr_in(cpu_addr), .cpu_cs_in(cpu_cs), .cpu_rd_in(cpu_rd), .cpu_wr_in(cpu_wr),
        .cpu_wdata_in(cpu_wdata), .cpu_ready_out(cpu_ready_out), .cpu_ack_out(cpu_ack_out),
        .cpu_rdata_out(cpu_rdata_out), .upd_valid_in(upd_valid), .upd_port_in(upd_port),
        .upd_count_in(upd_count), .upd_last_seq_in(upd_seq), .upd_last_good_in(upd_good),
        .upd_fast_state_in(upd_fast), .upd_cd_state_in(upd_cd), .upd_rts_in(upd_rts),
        .upd_rts_valid_in(upd_rts_v), .upd_prev_valid_seq_in(upd_pv), .upd_wr_adv_in(upd_wr_adv),
        .upd_rd_avg_in(upd_rd_avg), .look_port_in(look_port), .look_tdm_rd_ptr_in(look_rd),
        .look_dest_port_out(look_dest_port_out), .look_srts_en_out(look_srts_en_out),
        .look_adapt_en_out(look_adapt_en_out), .look_max_lead_out(look_max_lead_out),
        .look_wr_ptr_out(look_wr_ptr_out), .look_fill_out(look_fill_out),
        .look_lead_over_out(look_lead_over_out), .look_rts_out(look_rts_out),
        .look_rts_valid_out(look_rts_valid_out), .look_init_out(look_init_out),
        .look_cd_state_out(look_cd_state_out), .look_fast_state_out(look_fast_state_out));
    // ==========================================
    // Checking and bus tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [19:0] wa(input int p, input int w);
        return 20'(`URS_BASE_ADDR + p * `URS_STRUCT_BYTES + w * 2);
    endfunction
    // Held until the taking edge; ack is looked at just after that edge and up to four later edges
    task automatic cpu_op(input logic wr, input logic [19:0] a, input logic [15:0] d);
        int i;
        cpu_cs = 1'b1;
        cpu_rd = ~wr;
        cpu_wr = wr;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge clock_in);
        for (i = 0; i < 4 && cpu_ready_out !== 1'b1; i++) begin
            @(posedge clock_in);
        end
        #1;
        cpu_cs = 1'b0;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        for (i = 0; i < 4 && cpu_ack_out !== 1'b1; i++) begin
            @(posedge clock_in);
            #1;
        end
        check("ack", {15'h0000, cpu_ack_out}, 16'h0001);
        if (cpu_ack_out !== 1'b1) close_out();
        @(posedge clock_in);
        #1;
    endtask
    task automatic rd_chk(input string nm, input logic [19:0] a, input logic [15:0] e);
        cpu_op(1'b0, a, 16'h0000);
        check(nm, cpu_rdata_out, e);
    endtask
    // Extra idle edge so the strobe is never raised in the step that lowered it
    task automatic upd(input logic [4:0] p, input logic [7:0] c);
        upd_port = p;
        upd_count = c;
        upd_valid = 1'b1;
        #1;
        check("ready", {15'h0000, cpu_ready_out}, 16'h0000);
        @(posedge clock_in);
        #1;
        upd_valid = 1'b0;
        @(posedge clock_in);
        #1;
    endtask
    task automatic look(input logic [4:0] p, input logic [11:0] rp);
        look_port = p;
        look_rd = rp;
        @(posedge clock_in);
        #1;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        rd_chk("cleared stats", wa(0, `URS_W_CELLS), 16'h0000);
        rd_chk("cleared arrival", wa(27, `URS_W_ARR_RO), 16'h0000);
        $display("test reset done");
        for (int p = 0; p < `URS_PORTS; p++) begin
            cpu_op(1'b1, wa(p, `URS_W_PORT_CLK), 16'(p));
            cpu_op(1'b1, wa(p, `URS_W_MAX_LEAD), 16'(p * 3 + 1));
        end
        for (int p = 0; p < `URS_PORTS; p++) begin
            rd_chk("port word", wa(p, `URS_W_PORT_CLK), 16'(p));
            rd_chk("lead word", wa(p, `URS_W_MAX_LEAD), 16'(p * 3 + 1));
        end
        cpu_op(1'b1, 20'hBD000, 16'h1234);
        rd_chk("unmapped", 20'hBD000, 16'h0000);
        cpu_op(1'b1, wa(6, `URS_W_RD_AVG), 16'h0ABC);
        rd_chk("read only", wa(6, `URS_W_RD_AVG), 16'h0000);
        $display("test layout done");
        {upd_seq, upd_good, upd_fast, upd_cd} = {3'h5, 3'h3, 4'hA, 1'b1};
        {upd_rts, upd_rts_v, upd_pv} = {3'h7, 3'h7, 3'h7};
        upd(5'h03, 8'h01);
        rd_chk("seq state", wa(3, `URS_W_TS_SEQ), 16'h02BA);
        rd_chk("init word", wa(3, `URS_W_INIT_CD), 16'h0018);
        rd_chk("cells", wa(3, `URS_W_CELLS), 16'h0001);
        rd_chk("arrival", wa(3, `URS_W_ARR_RO), 16'h8000);
        look(5'h03, 12'h000);
        check("cd", {11'h000, look_cd_state_out, look_fast_state_out}, 16'h001A);
        clk_en = 1'b0;
        upd(5'h03, 8'h01);
        clk_en = 1'b1;
        rd_chk("frozen", wa(3, `URS_W_CELLS), 16'h0001);
        $display("test update done");
        cpu_op(1'b1, wa(2, `URS_W_PORT_CLK), 16'h0022);
        {upd_seq, upd_good, upd_fast, upd_cd} = {3'h0, 3'h0, 4'h0, 1'b0};
        {upd_rts, upd_rts_v, upd_pv} = {3'h6, 3'h5, 3'h4};
        upd(5'h02, 8'h00);
        rd_chk("time stamp", wa(2, `URS_W_TS_SEQ), 16'hB800);
        rd_chk("prev valid", wa(2, `URS_W_INIT_CD), 16'h0014);
        look(5'h02, 12'h000);
        check("look", {look_dest_port_out, look_srts_en_out, look_rts_out, look_rts_valid_out,
            look_init_out, 3'h0}, {5'h02, 1'b1, 3'h6, 3'h5, 1'b1, 3'h0});
        $display("test srts done");
        {upd_rts, upd_rts_v, upd_pv} = {3'h0, 3'h0, 3'h0};
        cpu_op(1'b1, wa(4, `URS_W_CELLS), 16'hFFFF);
        cpu_op(1'b1, wa(4, `URS_W_SEQ_HDR), 16'h00FF);
        upd(5'h04, 8'h03);
        rd_chk("cells wrap", wa(4, `URS_W_CELLS), 16'h0000);
        rd_chk("hdr wrap", wa(4, `URS_W_SEQ_HDR), 16'h0000);
        upd(5'h04, 8'h01);
        rd_chk("cells next", wa(4, `URS_W_CELLS), 16'h0001);
        rd_chk("rollover", wa(4, `URS_W_ARR_RO), 16'h8003);
        cpu_op(1'b1, wa(4, `URS_W_ARR_RO), 16'h0000);
        rd_chk("cleared", wa(4, `URS_W_ARR_RO), 16'h0000);
        $display("test rollover done");
        upd_rd_avg = 12'h123;
        upd(5'h05, 8'h20);
        rd_chk("rd avg", wa(5, `URS_W_RD_AVG), 16'h0123);
        rd_chk("underrun", wa(5, `URS_W_OVF_UND), 16'h0001);
        upd(5'h05, 8'h01);
        rd_chk("rd avg clear", wa(5, `URS_W_RD_AVG), 16'h0000);
        $display("test underrun done");
        cpu_op(1'b1, wa(6, `URS_W_PORT_CLK), 16'h0046);
        cpu_op(1'b1, wa(6, `URS_W_MAX_LEAD), 16'h0002);
        upd_wr_adv = 1'b1;
        upd(5'h06, 8'h00);
        upd(5'h06, 8'h00);
        upd_wr_adv = 1'b0;
        rd_chk("wr ptr", wa(6, `URS_W_WR_PTR), 16'h0002);
        look(5'h06, 12'hFFF);
        check("fill", {3'h0, look_adapt_en_out, look_fill_out}, 16'h1003);
        check("lead", {3'h0, look_lead_over_out, look_max_lead_out}, 16'h1002);
        check("wr look", {4'h0, look_wr_ptr_out}, 16'h0002);
        look(5'h1F, 12'h000);
        check("far port", {11'h000, look_dest_port_out}, 16'h0000);
        $display("test adaptive done");
        close_out();
    end
endmodule
